// ---- core/iadcs_sequencer.sv ----
// Incremental ADC sequencer: integration timer, pulse counter, modulator setup, APB
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
//
// Functional notes
// - Modulator ctrl 3 bit 4: zero holds integrator off, one lets it integrate.
// - Timer compare is 2^(bits+2); period is calculation time plus compare.
// - Compare-type bit picks count <= width or count < width.
// - Interrupt-type bit picks timer interrupt on compare or terminal count.
// - Each timer byte input register holds a 4-bit clock select; the upper one is stored but unused, the lower one paces both bytes.
// - Lower timer input upper nibble selects one of 16 enable sources.
// - Upper timer output: bit 2 output enable, low bits route the output.
// - 16-bit period loads the down counter on enable and terminal count.
// - 16-bit pulse width compared with down count gives compare event.
// - Lower control bit 0 runs the timer; upper run bit stays zero.
// - Pulse counter counts down, interrupts at terminal, reloads from reload register.
// - Pulse counter data select picks the column comparator output.
// - Pulse counter runs only while its control bit 0 is set.
// - Pulse counter data register lets software read the count.
// - Interrupt mask holds one enable for timer, one for pulse counter.
// - Modulator ctrl 1 upper three bits select the input multiplexer.
// - Modulator set up as integrator with reference feedback feeding comparator.
//
// Register map: byte address is four times the slot index.
// Slots 0x00-0x18 follow the register table; 0x19 status, 0x1A/0x1B result.
// Status bit 0 flags new data; software clears it by writing one.
`include "iadcs_defines.svh"

module iadcs_sequencer #(
  parameter int ADDR_W = 8,
  parameter int NUM_COLUMNS = 4
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [15:0] clk_src_i,
  input wire logic [15:0] enable_src_i,
  input wire logic [NUM_COLUMNS-1:0] column_cmp_i,
  output iadcs_pkg::iadcs_byte_type mod_ctrl_0_o,
  output iadcs_pkg::iadcs_byte_type mod_input_sel_o,
  output iadcs_pkg::iadcs_byte_type mod_ctrl_2_o,
  output iadcs_pkg::iadcs_byte_type mod_ctrl_3_o,
  output logic integrator_run_bit_o,
  output logic [3:0] timer_out_o,
  output logic timer_irq_o,
  output logic pulse_irq_o
);
  import iadcs_pkg::*;

  localparam int NREG = 32;

  // ****************************************
  // Register storage
  // ****************************************
  // Thirty-two byte slots cover the map; slots past the last index stay unused
  // Hardware-owned values (counts, result, status) live in their own flops
  iadcs_byte_type regs_q [NREG];
  iadcs_word_type tcount_q;
  iadcs_byte_type pcount_q;
  iadcs_byte_type pext_q;
  iadcs_word_type result_q;
  logic avail_q;
  logic run_q;
  logic cmp_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // Bus decode helpers
  logic [4:0] idx;
  logic mapped;
  logic wr_en;
  logic rd_en;
  // Only address bits 6:2 pick a slot; higher address bits are ignored
  // An index past the last register is refused with an error response
  assign idx = paddr_i[`IADCS_ADDR_HI:`IADCS_ADDR_LO];
  assign mapped = (idx <= `IADCS_LAST_INDEX);
  // Access cycle that the slave answers in the following cycle
  // Writes land at the first access edge, never again in the ready cycle
  assign wr_en = psel_i && penable_i && !pready_q && pwrite_i && mapped;
  assign rd_en = psel_i && penable_i && !pready_q && !pwrite_i;

  // Reset value of each stored register
  // Slots not listed here come up as zero
  function automatic iadcs_byte_type reset_val(input logic [4:0] i);
    unique case (i)
      `IADCS_MOD_CTRL_0: reset_val = `IADCS_RST_MOD_CTRL_0;
      `IADCS_MOD_CTRL_2: reset_val = `IADCS_RST_MOD_CTRL_2;
      `IADCS_MOD_CTRL_3: reset_val = `IADCS_RST_MOD_CTRL_3;
      `IADCS_TMH_FUNCTION: reset_val = `IADCS_RST_TMH_FUNCTION;
      `IADCS_TML_FUNCTION: reset_val = `IADCS_RST_TML_FUNCTION;
      `IADCS_TMH_INPUT: reset_val = `IADCS_RST_TMH_INPUT;
      `IADCS_PC_FUNCTION: reset_val = `IADCS_RST_PC_FUNCTION;
      `IADCS_PC_RELOAD: reset_val = `IADCS_RST_PC_RELOAD;
      default: reset_val = `IADCS_RST_ZERO;
    endcase
  endfunction : reset_val

  // Registers that software stores directly
  // Counts, snapshot, status and result are owned by hardware, so writes skip them
  // The upper run bit stays low because the lower byte starts the whole timer
  function automatic logic plain_rw(input logic [4:0] i);
    plain_rw = !(i == `IADCS_TMH_COUNT || i == `IADCS_TML_COUNT ||
                 i == `IADCS_PC_COUNT || i == `IADCS_PC_DATA_OUT ||
                 i == `IADCS_TMH_CONTROL || i == `IADCS_STATUS ||
                 i == `IADCS_RESULT_LO || i == `IADCS_RESULT_HI);
  endfunction : plain_rw

  // ****************************************
  // Control and data registers
  // ****************************************
  // One storage flop per entry; entries driven by hardware are kept constant here
  // Storage that the map leaves unused keeps its reset value
  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_reg
      localparam logic [4:0] IDX = 5'(g);
      always_ff @(posedge clk_i) begin
        if (reset_i) begin
          regs_q[g] <= reset_val(IDX);
        end else if (wr_en && idx == IDX && plain_rw(IDX)) begin
          regs_q[g] <= pwdata_i[7:0];
        end
      end
    end
  endgenerate

  // Named views of the stored fields
  // Field slices are named once so the logic below reads plainly
  iadcs_byte_type tmh_func, tml_func, tml_in, tmh_out, pc_in, pc_ctrl, int_mask;
  iadcs_word_type period, pulse_width;
  assign tmh_func = regs_q[`IADCS_TMH_FUNCTION];
  assign tml_func = regs_q[`IADCS_TML_FUNCTION];
  assign tml_in = regs_q[`IADCS_TML_INPUT];
  assign tmh_out = regs_q[`IADCS_TMH_OUTPUT];
  assign pc_in = regs_q[`IADCS_PC_INPUT];
  assign pc_ctrl = regs_q[`IADCS_PC_CONTROL];
  assign int_mask = regs_q[`IADCS_INT_MASK_1];
  // Software programs period = calculation time + compare, compare = 2^(bits+2)
  assign period = {regs_q[`IADCS_TMH_PERIOD], regs_q[`IADCS_TML_PERIOD]};
  assign pulse_width = {regs_q[`IADCS_TMH_PULSE], regs_q[`IADCS_TML_PULSE]};

  // ****************************************
  // Integration timer
  // ****************************************
  // Timer control and compare signals
  logic run;
  logic t_tick;
  logic t_tc;
  logic cmp_now;
  logic cmp_rise;
  logic cmp_evt;
  // The upper byte is chained to the lower byte, so the lower clock select paces both
  // A stopped timer keeps its count, so software may read both halves safely
  // A tick needs the selected clock source and the selected enable source high
  assign run = regs_q[`IADCS_TML_CONTROL][`IADCS_BIT_RUN];
  assign t_tick = run && run_q &&
                  clk_src_i[tml_in[`IADCS_CLK_HI:`IADCS_CLK_LO]] &&
                  enable_src_i[tml_in[`IADCS_SEL_HI:`IADCS_SEL_LO]];
  assign t_tc = t_tick && (tcount_q == '0);
  // Compare type chooses less-or-equal against strictly less
  assign cmp_now = tml_func[`IADCS_BIT_CMP_TYPE] ? (tcount_q <= pulse_width) :
                   (tcount_q < pulse_width);
  assign cmp_rise = cmp_now && !cmp_q;
  // The first run cycle still holds the stale count, so no compare event then
  assign cmp_evt = run && run_q && cmp_rise;

  // Remember run and compare levels for edge detection
  // Start of run shows as run high while run_q is still low
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      run_q <= 1'b0;
      cmp_q <= 1'b0;
    end else begin
      run_q <= run;
      cmp_q <= run && cmp_now;
    end
  end

  // Down counter: load on enable and terminal count, else count down
  // A period of N gives N+1 ticks between terminal counts
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tcount_q <= '0;
    end else if ((run && !run_q) || t_tc) begin
      tcount_q <= period;
    end else if (t_tick) begin
      tcount_q <= tcount_q - 16'h0001;
    end
  end

  // Timer interrupt event chosen by the interrupt-type bit, gated by its mask
  // Compare mode fires once per window, when the count first meets the width
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      timer_irq_o <= 1'b0;
    end else begin
      timer_irq_o <= int_mask[`IADCS_BIT_MASK_TIMER] &&
                     (tmh_func[`IADCS_BIT_IRQ_TYPE] ? t_tc : cmp_evt);
    end
  end

  // Output routing: one of four lines carries the compare level when enabled
  // Only one line is ever driven; the others stay low
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      timer_out_o <= 4'h0;
    end else begin
      timer_out_o <= '0;
      if (tmh_out[`IADCS_BIT_OUT_EN] && run) begin
        timer_out_o[tmh_out[`IADCS_OUTSEL_HI:`IADCS_OUTSEL_LO]] <= cmp_now;
      end
    end
  end

  // ****************************************
  // Comparator pulse counter
  // ****************************************
  // Pulse counter control signals
  logic [3:0] col_sel;
  logic p_data;
  logic p_tick;
  logic p_tc;
  // Upper nibble of the input register picks the comparator column
  assign col_sel = pc_in[`IADCS_SEL_HI:`IADCS_SEL_LO];
  // Selects outside the fitted columns count nothing
  // The clock select gates counting too, so a slow source slows the count
  assign p_data = (32'(col_sel) < NUM_COLUMNS) ?
                  column_cmp_i[col_sel[$clog2(NUM_COLUMNS)-1:0]] : 1'b0;
  assign p_tick = pc_ctrl[`IADCS_BIT_RUN] && p_data &&
                  clk_src_i[pc_in[`IADCS_CLK_HI:`IADCS_CLK_LO]];
  assign p_tc = p_tick && (pcount_q == '0);

  // Low byte counts pulses; the extension byte stands in for the software counter.
  // Both restart at each window end so every result covers one window only.
  // Limitation: more than 65535 pulses in one window wrap the extended count.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pcount_q <= `IADCS_RST_PC_RELOAD;
      pext_q <= `IADCS_RST_PC_RELOAD;
    end else if (t_tc) begin
      pcount_q <= regs_q[`IADCS_PC_RELOAD];
      pext_q <= `IADCS_RST_PC_RELOAD;
    end else if (p_tc) begin
      pcount_q <= regs_q[`IADCS_PC_RELOAD];
      pext_q <= pext_q - 8'h01;
    end else if (p_tick) begin
      pcount_q <= pcount_q - 8'h01;
    end
  end

  // Pulse counter terminal interrupt, gated by its mask
  // Software uses it to step a wider count of its own
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pulse_irq_o <= 1'b0;
    end else begin
      pulse_irq_o <= p_tc && int_mask[`IADCS_BIT_MASK_PULSE];
    end
  end

  // ****************************************
  // Conversion result
  // ****************************************
  // Result forming signals
  iadcs_word_type pulses;
  iadcs_byte_type snap_q;
  logic avail_clr;
  // Pulses seen = all ones minus the remaining extended count
  // No double buffer: an unread result is overwritten at the next window end
  assign pulses = 16'hFFFF - {pext_q, pcount_q};
  assign avail_clr = wr_en && idx == `IADCS_STATUS && pwdata_i[`IADCS_BIT_AVAIL];

  // Signed result centred on half the integration count; new data overwrites old
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      result_q <= '0;
    end else if (t_tc) begin
      result_q <= pulses - {1'b0, pulse_width[15:1]};
    end
  end

  // Data available: a window end in the clearing cycle keeps the flag set
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      avail_q <= 1'b0;
    end else if (t_tc) begin
      avail_q <= 1'b1;
    end else if (avail_clr) begin
      avail_q <= 1'b0;
    end
  end

  // A write to the data-out register snapshots the live count for a stable read
  // Reading the live count directly could tear while pulses arrive
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      snap_q <= '0;
    end else if (wr_en && idx == `IADCS_PC_DATA_OUT) begin
      snap_q <= pcount_q;
    end
  end

  // ****************************************
  // Modulator control outputs
  // ****************************************
  // Registered copies; integrator run follows ctrl 3 bit 4 directly
  // One cycle of delay keeps every modulator output straight from a flop
  // Input select bits pass untouched; the placement decides what they mean
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mod_ctrl_0_o <= `IADCS_RST_MOD_CTRL_0;
      mod_input_sel_o <= `IADCS_RST_ZERO;
      mod_ctrl_2_o <= `IADCS_RST_MOD_CTRL_2;
      mod_ctrl_3_o <= `IADCS_RST_MOD_CTRL_3;
      integrator_run_bit_o <= 1'b0;
    end else begin
      mod_ctrl_0_o <= regs_q[`IADCS_MOD_CTRL_0];
      mod_input_sel_o <= regs_q[`IADCS_MOD_INPUT_SEL];
      mod_ctrl_2_o <= regs_q[`IADCS_MOD_CTRL_2];
      mod_ctrl_3_o <= regs_q[`IADCS_MOD_CTRL_3];
      integrator_run_bit_o <= regs_q[`IADCS_MOD_CTRL_3][`IADCS_BIT_INTEGRATE];
    end
  end

  // ****************************************
  // APB read path
  // ****************************************
  iadcs_byte_type rd_byte;
  // Hardware-owned registers override storage; unmapped reads return zero
  // Read data is captured once, at the first access edge, then held
  // Held data lets software look at prdata again after the transfer
  always_comb begin
    rd_byte = mapped ? regs_q[idx] : `IADCS_RST_ZERO;
    unique case (idx)
      `IADCS_TMH_COUNT: rd_byte = tcount_q[15:8];
      `IADCS_TML_COUNT: rd_byte = tcount_q[7:0];
      `IADCS_TMH_CONTROL: rd_byte = `IADCS_RST_ZERO;
      `IADCS_PC_COUNT: rd_byte = pcount_q;
      `IADCS_PC_DATA_OUT: rd_byte = snap_q;
      `IADCS_STATUS: rd_byte = {7'h00, avail_q};
      `IADCS_RESULT_LO: rd_byte = result_q[7:0];
      `IADCS_RESULT_HI: rd_byte = result_q[15:8];
      default: rd_byte = rd_byte;
    endcase
  end

  // One wait state: answer in the cycle after the first access cycle
  // An error response rides on the same ready pulse
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= psel_i && penable_i && !pready_q;
      pslverr_q <= psel_i && penable_i && !pready_q && !mapped;
      if (rd_en) begin
        prdata_q <= {24'h000000, rd_byte};
      end
    end
  end

  // Bus outputs come straight from their flops
  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
endmodule : iadcs_sequencer

// ---- inc/iadcs_defines.svh ----
// Register indices, field positions, reset values and sizes of the ADC sequencer
`ifndef IADCS_DEFINES_SVH
`define IADCS_DEFINES_SVH
// ****************************************
// Register indices (byte address = 4 * index)
// ****************************************
`define IADCS_MOD_CTRL_0 5'h00
`define IADCS_MOD_INPUT_SEL 5'h01
`define IADCS_MOD_CTRL_2 5'h02
`define IADCS_MOD_CTRL_3 5'h03
`define IADCS_TMH_FUNCTION 5'h04
`define IADCS_TML_FUNCTION 5'h05
`define IADCS_TMH_INPUT 5'h06
`define IADCS_TML_INPUT 5'h07
`define IADCS_TMH_OUTPUT 5'h08
`define IADCS_TML_OUTPUT 5'h09
`define IADCS_TMH_COUNT 5'h0A
`define IADCS_TML_COUNT 5'h0B
`define IADCS_TMH_PERIOD 5'h0C
`define IADCS_TML_PERIOD 5'h0D
`define IADCS_TMH_PULSE 5'h0E
`define IADCS_TML_PULSE 5'h0F
`define IADCS_TMH_CONTROL 5'h10
`define IADCS_TML_CONTROL 5'h11
`define IADCS_PC_FUNCTION 5'h12
`define IADCS_PC_INPUT 5'h13
`define IADCS_PC_COUNT 5'h14
`define IADCS_PC_RELOAD 5'h15
`define IADCS_PC_DATA_OUT 5'h16
`define IADCS_PC_CONTROL 5'h17
`define IADCS_INT_MASK_1 5'h18
`define IADCS_STATUS 5'h19
`define IADCS_RESULT_LO 5'h1A
`define IADCS_RESULT_HI 5'h1B
`define IADCS_LAST_INDEX 5'h1B
// ****************************************
// Reset values
// ****************************************
`define IADCS_RST_MOD_CTRL_0 8'h90
`define IADCS_RST_MOD_CTRL_2 8'h60
`define IADCS_RST_MOD_CTRL_3 8'hE0
`define IADCS_RST_TMH_FUNCTION 8'h21
`define IADCS_RST_TML_FUNCTION 8'h01
`define IADCS_RST_TMH_INPUT 8'h30
`define IADCS_RST_PC_FUNCTION 8'h21
`define IADCS_RST_PC_RELOAD 8'hFF
`define IADCS_RST_ZERO 8'h00
// ****************************************
// Field positions
// ****************************************
`define IADCS_BIT_RUN 0
`define IADCS_BIT_INTEGRATE 4
`define IADCS_BIT_CMP_TYPE 4
`define IADCS_BIT_IRQ_TYPE 3
`define IADCS_BIT_OUT_EN 2
`define IADCS_OUTSEL_HI 1
`define IADCS_OUTSEL_LO 0
`define IADCS_BIT_MASK_TIMER 0
`define IADCS_BIT_MASK_PULSE 1
`define IADCS_BIT_AVAIL 0
`define IADCS_SEL_HI 7
`define IADCS_SEL_LO 4
`define IADCS_CLK_HI 3
`define IADCS_CLK_LO 0
`define IADCS_MUX_HI 7
`define IADCS_MUX_LO 5
`define IADCS_ADDR_HI 6
`define IADCS_ADDR_LO 2
`endif

// ---- inc/iadcs_pkg.sv ----
// Types shared by the ADC sequencer
package iadcs_pkg;
  typedef logic [7:0] iadcs_byte_type;
  typedef logic [15:0] iadcs_word_type;
endpackage : iadcs_pkg

// ---- sim/iadcs_modulator_model.sv ----
// Behavioural switched-capacitor modulator and its column comparators
`timescale 1ns/100ps
module iadcs_modulator_model #(
  parameter int NUM_COLUMNS = 4,
  parameter int COLUMN = 0
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic run_i,
  input wire logic [7:0] level_i,
  output logic [NUM_COLUMNS-1:0] cmp_o
);
  logic [8:0] acc_q;
  // Integrator with reference feedback: the carry is the pulse stream
  always_ff @(posedge clk_i) begin
    if (reset_i || !run_i) begin
      acc_q <= 9'h000;
    end else begin
      acc_q <= {1'b0, acc_q[7:0]} + {1'b0, level_i};
    end
  end
  // Only our column carries pulses; the others show its inverse
  always_comb begin
    cmp_o = {NUM_COLUMNS{~acc_q[8]}};
    cmp_o[COLUMN] = acc_q[8];
  end
endmodule : iadcs_modulator_model

// ---- sim/iadcs_sequencer_asserts.sv ----
// Port-level assertions for the ADC sequencer
`timescale 1ns/100ps
module iadcs_seq_checker #(
  parameter int ADDR_W = 8,
  parameter int NUM_COLUMNS = 4
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [7:0] mod_ctrl_0_o,
  input wire logic [7:0] mod_input_sel_o,
  input wire logic [7:0] mod_ctrl_3_o,
  input wire logic integrator_run_bit_o,
  input wire logic [3:0] timer_out_o,
  input wire logic timer_irq_o,
  input wire logic pulse_irq_o
);
  // *********
  // Helpers
  // *********
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  // First access cycle: the edge where the slave takes a request
  logic take;
  assign take = psel_i && penable_i && !pready_o;
  // *********
  // Checks
  // *********
  a_ready_one_wait: assert property (take |=> pready_o)
    else $error("ready missing after access");
  a_ready_single: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  a_err_unmapped: assert property (take && paddr_i[6:2] > 5'h1B |=> pslverr_o)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (take && paddr_i[6:2] <= 5'h1B |=> !pslverr_o)
    else $error("mapped access refused");
  a_err_with_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  // Read data may only move with a response, so software never sees a torn value
  a_rdata_hold: assert property (!$stable(prdata_o) |-> pready_o)
    else $error("read data changed outside response");
  a_integ_follow: assert property (
    take && pwrite_i && paddr_i[6:2] == 5'h03 |-> ##2
    integrator_run_bit_o == $past(pwdata_i[4], 2))
    else $error("integrator bit does not follow write");
  a_mux_follow: assert property (
    take && pwrite_i && paddr_i[6:2] == 5'h01 |-> ##2
    mod_input_sel_o[7:5] == $past(pwdata_i[7:5], 2))
    else $error("input select does not follow write");
  a_out_onehot: assert property ($onehot0(timer_out_o))
    else $error("timer output routed to several pins");
  a_reset_state: assert property (disable iff (1'b0) reset_i |=>
    mod_ctrl_0_o == 8'h90 && mod_ctrl_3_o == 8'hE0 && !integrator_run_bit_o
    && !timer_irq_o && !pulse_irq_o && !pready_o)
    else $error("outputs wrong in reset");
endmodule : iadcs_seq_checker

bind iadcs_sequencer iadcs_seq_checker #(.ADDR_W(ADDR_W), .NUM_COLUMNS(NUM_COLUMNS)) u_chk (
  .clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .mod_ctrl_0_o(mod_ctrl_0_o),
  .mod_input_sel_o(mod_input_sel_o), .mod_ctrl_3_o(mod_ctrl_3_o),
  .integrator_run_bit_o(integrator_run_bit_o), .timer_out_o(timer_out_o),
  .timer_irq_o(timer_irq_o), .pulse_irq_o(pulse_irq_o));

// ---- sim/iadcs_sequencer_tb_top.sv ----
// Self-checking testbench for the ADC sequencer
`timescale 1ns/100ps
module iadcs_sequencer_tb_top;
  logic clk_i, reset_i, psel, penable, pwrite, pready, pslverr, integ, tirq, pirq;
  logic [7:0] paddr, level, rd_q;
  logic [31:0] pwdata, prdata;
  logic [15:0] clk_src, en_src;
  logic [3:0] cmp, tout;
  logic err_q;
  iadcs_pkg::iadcs_byte_type mc0, mc1, mc2, mc3;
  int miscompares = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;
  int hi;
  // *********
  // Instances
  // *********
  iadcs_sequencer dut (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .clk_src_i(clk_src),
    .enable_src_i(en_src), .column_cmp_i(cmp), .mod_ctrl_0_o(mc0),
    .mod_input_sel_o(mc1), .mod_ctrl_2_o(mc2), .mod_ctrl_3_o(mc3),
    .integrator_run_bit_o(integ), .timer_out_o(tout), .timer_irq_o(tirq),
    .pulse_irq_o(pirq));
  iadcs_modulator_model u_mod (.clk_i(clk_i), .reset_i(reset_i), .run_i(integ),
    .level_i(level), .cmp_o(cmp));
  // *********
  // Helpers
  // *********
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; request held until pready is seen at an edge
  // Only the bench timeout ends a wait that never gets its answer
  task automatic apb(input logic w, input logic [4:0] idx, input logic [7:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {1'b0, idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready !== 1'b1);
    rd_q = prdata[7:0];
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Bounded wait for an interrupt pulse; n reaches lim when none came
  task automatic wait_irq(input logic pulse, input int lim);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while ((pulse ? pirq : tirq) !== 1'b1 && n < lim);
  endtask : wait_irq
  // *********
  // Scenarios
  // *********
  task automatic t_reset();
    chk(mc0, 8'h90);
    chk(mc2, 8'h60);
    chk(mc3, 8'hE0);
    chk({7'h00, integ}, 8'h00);
    apb(1'b0, 5'h04, 8'h00);
    chk(rd_q, 8'h21);
    apb(1'b0, 5'h15, 8'h00);
    chk(rd_q, 8'hFF);
    apb(1'b1, 5'h0A, 8'h55);
    apb(1'b0, 5'h0A, 8'h00);
    chk(rd_q, 8'h00);
    apb(1'b0, 5'h1C, 8'h00);
    chk({7'h00, err_q}, 8'h01);
    apb(1'b1, 5'h0D, 8'h5A);
    apb(1'b0, 5'h0D, 8'h00);
    chk(rd_q, 8'h5A);
  endtask : t_reset
  task automatic t_modulator();
    apb(1'b1, 5'h03, 8'hF0);
    apb(1'b1, 5'h01, 8'hA0);
    repeat (3) @(posedge clk_i);
    chk({7'h00, integ}, 8'h01);
    chk({mc1[7:5], 5'h00}, 8'hA0);
    apb(1'b1, 5'h03, 8'hE0);
    repeat (3) @(posedge clk_i);
    chk({7'h00, integ}, 8'h00);
  endtask : t_modulator
  // Period 9 gives ten ticks between terminals, in both interrupt modes
  task automatic t_timer();
    apb(1'b1, 5'h0D, 8'h09);
    apb(1'b1, 5'h0F, 8'h04);
    apb(1'b1, 5'h18, 8'h01);
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, 5'h04, m[0] ? 8'h29 : 8'h21);
      apb(1'b1, 5'h11, 8'h01);
      wait_irq(1'b0, 200);
      wait_irq(1'b0, 40);
      chk(n[7:0], 8'd10);
      apb(1'b1, 5'h11, 8'h00);
    end
    apb(1'b0, 5'h10, 8'h00);
    chk(rd_q, 8'h00);
    apb(1'b0, 5'h0A, 8'h00);
    chk(rd_q, 8'h00);
    apb(1'b0, 5'h19, 8'h00);
    chk(rd_q & 8'h01, 8'h01);
    apb(1'b1, 5'h19, 8'h01);
    apb(1'b0, 5'h19, 8'h00);
    chk(rd_q & 8'h01, 8'h00);
    // Clock select 1 with that source idle: the timer must not move
    clk_src <= 16'h0001;
    apb(1'b1, 5'h07, 8'h01);
    apb(1'b1, 5'h11, 8'h01);
    wait_irq(1'b0, 40);
    chk(n[7:0], 8'd40);
    clk_src <= 16'hFFFF;
    wait_irq(1'b0, 40);
    chk({7'h00, n < 40}, 8'h01);
    // Enable select 1 with that source low: the timer must stall
    en_src <= 16'h0001;
    apb(1'b1, 5'h07, 8'h10);
    wait_irq(1'b0, 40);
    chk(n[7:0], 8'd40);
    en_src <= 16'hFFFF;
    apb(1'b1, 5'h18, 8'h00);
    wait_irq(1'b0, 40);
    chk(n[7:0], 8'd40);
    apb(1'b1, 5'h11, 8'h00);
    apb(1'b1, 5'h07, 8'h00);
  endtask : t_timer
  // Width 4 inside period 9: five high counts for <=, four for <
  task automatic t_compare();
    apb(1'b1, 5'h08, 8'h05);
    for (int c = 0; c < 2; c++) begin
      apb(1'b1, 5'h05, c[0] ? 8'h11 : 8'h01);
      apb(1'b1, 5'h11, 8'h01);
      repeat (15) @(posedge clk_i);
      hi = 0;
      repeat (10) begin
        @(posedge clk_i);
        hi += (tout === 4'b0010) ? 1 : 0;
      end
      chk(hi[7:0], c[0] ? 8'd5 : 8'd4);
      apb(1'b1, 5'h11, 8'h00);
    end
  endtask : t_compare
  task automatic t_pulse();
    apb(1'b1, 5'h03, 8'hF0);
    apb(1'b1, 5'h13, 8'h00);
    apb(1'b1, 5'h18, 8'h02);
    apb(1'b1, 5'h17, 8'h01);
    wait_irq(1'b1, 1500);
    chk({7'h00, n < 1500}, 8'h01);
    apb(1'b1, 5'h17, 8'h00);
    wait_irq(1'b1, 600);
    chk({7'h00, n == 600}, 8'h01);
    apb(1'b0, 5'h14, 8'h00);
    hi = rd_q;
    apb(1'b1, 5'h16, 8'h00);
    apb(1'b0, 5'h16, 8'h00);
    chk(rd_q, hi[7:0]);
  endtask : t_pulse
  // *********
  // Run
  // *********
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Cuts a hang short; the whole run needs about 1500 cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      $display("FAIL %0t timeout", $time);
      give_verdict();
    end
  end
  initial begin
    {reset_i, psel, penable, pwrite} = 4'b1000;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    clk_src = 16'hFFFF;
    en_src = 16'hFFFF;
    level = 8'h80;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    t_reset();
    t_modulator();
    t_timer();
    t_compare();
    t_pulse();
    give_verdict();
  end
endmodule : iadcs_sequencer_tb_top
